// *** design/ptumd_mode_select.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "ptumd_params.svh"

module ptumd_mode_select #(
    parameter int NUM_CH = `PTUMD_NUM_CH
) (
    input  wire logic                    mclk,
    input  wire logic                    rst,
    input  wire logic [7:0]              avs_address,
    input  wire logic                    avs_read,
    input  wire logic                    avs_write,
    input  wire logic [31:0]             avs_writedata,
    input  wire logic [3:0]              avs_byteenable,
    output logic [31:0]                  avs_readdata,
    output logic                         avs_waitrequest,
    input  wire logic [NUM_CH-1:0]       counter_running,
    output ptumd_pkg::ptumd_mode_e       chan_mode [NUM_CH],
    output logic [NUM_CH-1:0]            buf_a_active,
    output logic [NUM_CH-1:0]            buf_b_active,
    output logic [NUM_CH-1:0]            reg_c_events_en,
    output logic [NUM_CH-1:0]            reg_d_events_en,
    output logic [NUM_CH-1:0]            reg_c_ioctl_en,
    output logic [NUM_CH-1:0]            reg_d_ioctl_en,
    output logic [NUM_CH-1:0]            clk_sel_en,
    output logic [NUM_CH-1:0]            mode_undefined,
    output logic [NUM_CH-1:0]            write_while_running
);
    import ptumd_pkg::*;

    // ------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------
    // One wait cycle per access, so read data comes from a flop
    logic                 ack_r;
    logic                 ack_nxt;
    logic                 req;
    logic [31:0]          rdata_r;
    logic [31:0]          rdata_nxt;
    logic [NUM_CH-1:0]    sel;
    logic [NUM_CH-1:0]    wr_hit;
    logic                 run_sel;
    logic                 lane0;
    logic [7:0]           wbyte;
    ptumd_byte_t          mode_r [NUM_CH];
    logic [NUM_CH-1:0]    wrun_r;
    logic [NUM_CH-1:0]    wrun_nxt;

    assign req             = avs_read | avs_write;
    assign ack_nxt         = req & ~ack_r;
    assign avs_waitrequest = req & ~ack_r;
    assign avs_readdata    = rdata_r;
    assign lane0           = avs_byteenable[0];
    assign wbyte           = avs_writedata[7:0];
    assign run_sel         = (avs_address == `PTUMD_OFS_RUN);

    always_ff @(posedge mclk) begin
        if (rst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= ack_nxt;
        end
    end

    // ------------------------------------------------------------
    // Per-channel mode registers
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            localparam logic HAS_CD = (g == 0) || (g == 3);
            logic       wr_ok;
            logic [7:0] wmask;
            logic [7:0] mode_nxt;
            logic [2:0] fld;
            logic       phase;
            logic       buf_a;
            logic       buf_b;

            assign sel[g] = (avs_address ==
                8'(`PTUMD_OFS_MODE0 + g * `PTUMD_OFS_STRIDE));
            // Write lands on the edge where waitrequest is seen low
            assign wr_hit[g] = sel[g] & avs_write & ack_r & lane0;
            // Writes while counting are flagged, not blocked
            assign wr_ok = wr_hit[g];
            // Fixed and reserved bits never take a write
            assign wmask = HAS_CD ? 8'h3f : 8'h0f;
            assign mode_nxt = wr_ok
                ? ((wbyte & wmask) | `PTUMD_FIX_ONES)
                : mode_r[g];

            always_ff @(posedge mclk) begin
                if (rst) begin
                    mode_r[g] <= `PTUMD_MODE_RESET;
                end else begin
                    mode_r[g] <= mode_nxt;
                end
            end

            assign fld   = mode_r[g][2:0];
            assign buf_a = HAS_CD & mode_r[g][`PTUMD_BIT_BUF_A];
            assign buf_b = HAS_CD & mode_r[g][`PTUMD_BIT_BUF_B];
            assign phase = mode_r[g][`PTUMD_BIT_MODE_PHASE];

            // Top bit set, 0001, or phase on channels 0/3: undefined
            assign mode_undefined[g] = mode_r[g][`PTUMD_BIT_MODE_TOP]
                | (fld == 3'b001)
                | (HAS_CD & phase);

            always_comb begin
                if (mode_undefined[g]) begin
                    chan_mode[g] = PTUMD_UNDEF;
                end else begin
                    case (fld)
                        3'b000:  chan_mode[g] = PTUMD_NORMAL;
                        3'b010:  chan_mode[g] = PTUMD_PWM1;
                        3'b011:  chan_mode[g] = PTUMD_PWM2;
                        3'b100:  chan_mode[g] = PTUMD_PHASE1;
                        3'b101:  chan_mode[g] = PTUMD_PHASE2;
                        3'b110:  chan_mode[g] = PTUMD_PHASE3;
                        3'b111:  chan_mode[g] = PTUMD_PHASE4;
                        default: chan_mode[g] = PTUMD_UNDEF;
                    endcase
                end
            end

            assign buf_a_active[g]    = buf_a;
            assign buf_b_active[g]    = buf_b;
            assign reg_c_events_en[g] = HAS_CD & ~buf_a;
            assign reg_d_events_en[g] = HAS_CD & ~buf_b;
            assign reg_c_ioctl_en[g]  = HAS_CD & ~buf_a;
            assign reg_d_ioctl_en[g]  = HAS_CD & ~buf_b;
            // Phase counting takes its clock from the phase pins
            assign clk_sel_en[g] = HAS_CD
                | ~(phase & ~mode_undefined[g]);

            assign wrun_nxt[g] = wrun_r[g]
                | (wr_hit[g] & counter_running[g]);
        end
    endgenerate

    // ------------------------------------------------------------
    // Write-while-running sticky status
    // ------------------------------------------------------------
    logic [NUM_CH-1:0] wrun_clr;
    logic [NUM_CH-1:0] wrun_set;

    assign wrun_set = wrun_nxt & ~wrun_r;
    assign wrun_clr = (run_sel & avs_write & ack_r & lane0)
        ? wbyte[NUM_CH-1:0] : '0;

    always_ff @(posedge mclk) begin
        if (rst) begin
            wrun_r <= '0;
        end else begin
            // A same-cycle clear wins over a new event on a bit already set
            wrun_r <= (wrun_r & ~wrun_clr) | wrun_set;
        end
    end

    assign write_while_running = wrun_r;

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    always_comb begin
        rdata_nxt = `PTUMD_UNMAPPED_DATA;
        for (int i = 0; i < NUM_CH; i++) begin
            if (sel[i]) begin
                rdata_nxt = {24'h00_0000, mode_r[i]};
            end
        end
        if (run_sel) begin
            rdata_nxt = 32'(wrun_r);
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata_r <= 32'h0000_0000;
        end else if (avs_read & ack_nxt) begin
            rdata_r <= rdata_nxt;
        end
    end

endmodule
`default_nettype wire

// *** design/ptumd_params.svh ***
`ifndef PTUMD_PARAMS_SVH
`define PTUMD_PARAMS_SVH

// Register byte offsets, one aligned word per channel
`define PTUMD_OFS_MODE0      8'h00
`define PTUMD_OFS_STRIDE     8'h04
`define PTUMD_OFS_RUN        8'h18
`define PTUMD_NUM_CH         6

// Mode register field positions
`define PTUMD_BIT_FIX_HI     7
`define PTUMD_BIT_FIX_LO     6
`define PTUMD_BIT_BUF_B      5
`define PTUMD_BIT_BUF_A      4
`define PTUMD_BIT_MODE_TOP   3
`define PTUMD_BIT_MODE_PHASE 2

// Reset value and fixed bits
`define PTUMD_MODE_RESET     8'hc0
`define PTUMD_FIX_ONES       8'hc0
`define PTUMD_UNMAPPED_DATA  32'h0000_0000

`endif

// *** design/ptumd_pkg.sv ***
package ptumd_pkg;

    typedef enum logic [2:0] {
        PTUMD_NORMAL = 3'b000,
        PTUMD_PWM1   = 3'b001,
        PTUMD_PWM2   = 3'b010,
        PTUMD_PHASE1 = 3'b011,
        PTUMD_PHASE2 = 3'b100,
        PTUMD_PHASE3 = 3'b101,
        PTUMD_PHASE4 = 3'b110,
        PTUMD_UNDEF  = 3'b111
    } ptumd_mode_e;

    typedef logic [7:0] ptumd_byte_t;

endpackage

// *** testbench/ptumd_mode_select_props.sv ***
`timescale 1ns/10ps
`default_nettype none
module ptumd_mode_select_props #(
    parameter int NUM_CH = 6
) (
    input wire logic              mclk,
    input wire logic              rst,
    input wire logic              avs_read,
    input wire logic              avs_write,
    input wire logic [31:0]       avs_readdata,
    input wire logic              avs_waitrequest,
    input wire logic [NUM_CH-1:0] buf_a_active,
    input wire logic [NUM_CH-1:0] buf_b_active,
    input wire logic [NUM_CH-1:0] reg_c_events_en,
    input wire logic [NUM_CH-1:0] reg_d_events_en,
    input wire logic [NUM_CH-1:0] reg_c_ioctl_en,
    input wire logic [NUM_CH-1:0] mode_undefined
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // One wait cycle, then the answer
    sequence one_wait_s;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence
    wait_one_a: assert property ($rose(avs_read || avs_write) |-> one_wait_s)
        else $error("access not answered after one wait");
    rst_clear_a: assert property (disable iff (1'b0) rst |=>
        buf_a_active == '0 && buf_b_active == '0 && mode_undefined == '0)
        else $error("buffer or mode not cleared by reset");
    c_quiet_a: assert property ((buf_a_active & reg_c_events_en) == '0)
        else $error("buffer C still makes events");
    d_quiet_a: assert property ((buf_b_active & reg_d_events_en) == '0)
        else $error("buffer D still makes events");
    c_ioctl_a: assert property ((buf_a_active & reg_c_ioctl_en) == '0)
        else $error("buffer C honours its I/O control");
    pair_chan_a: assert property (((buf_a_active | buf_b_active) & 6'h36) == '0)
        else $error("buffering on a channel without C or D");
    buf_hold_a: assert property (!avs_write |=> $stable(buf_a_active))
        else $error("buffer pairing changed without a write");
    rdata_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
        else $error("read data changed without a read");
endmodule
bind ptumd_mode_select ptumd_mode_select_props #(.NUM_CH(NUM_CH)) chk (.*);
`default_nettype wire

// *** testbench/testbench.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
    n_mismatch++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module testbench;
    import ptumd_pkg::*;
    logic        mclk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic        avs_waitrequest, full;
    logic [7:0]  avs_address = 8'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rdata;
    logic [3:0]  avs_byteenable = 4'h1;
    logic [5:0]  counter_running = 6'h00, buf_a_active, buf_b_active;
    logic [5:0]  reg_c_events_en, reg_d_events_en, reg_c_ioctl_en;
    logic [5:0]  reg_d_ioctl_en, clk_sel_en, mode_undefined;
    logic [5:0]  write_while_running;
    ptumd_mode_e chan_mode [6];
    ptumd_mode_e exp_mode [9] = '{PTUMD_NORMAL, PTUMD_UNDEF, PTUMD_PWM1,
        PTUMD_PWM2, PTUMD_PHASE1, PTUMD_PHASE2, PTUMD_PHASE3, PTUMD_PHASE4,
        PTUMD_UNDEF};
    int          n_mismatch = 0, num_checks = 0, cycles = 0;

    ptumd_mode_select uut (.*);

    initial begin
        forever #2 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // One bus access, held until waitrequest is seen low
    task automatic acc(input logic w, input logic [7:0] a,
                       input logic [7:0] d);
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_write <= w;
        avs_read <= !w;
        @(posedge mclk iff !avs_waitrequest);
        rdata = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(negedge mclk);
    endtask

    initial begin
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        for (int c = 0; c < 6; c++) begin
            acc(1'b0, 8'(4 * c), 8'h00);
            `CHK("mode_rst", 32'hc0, rdata)
        end
        // Buffers on channels 0/3, phase mode on the other channels
        for (int c = 0; c < 6; c++) begin
            full = (c % 3 == 0);
            acc(1'b1, 8'(4 * c), full ? 8'h33 : 8'h37);
            acc(1'b0, 8'(4 * c), 8'h00);
            `CHK("mode_rd", full ? 32'hf3 : 32'hc7, rdata)
            `CHK("buf_a", full, buf_a_active[c])
            `CHK("buf_b", full, buf_b_active[c])
            `CHK("c_evt", 1'b0, reg_c_events_en[c])
            `CHK("d_io", 1'b0, reg_d_ioctl_en[c])
            `CHK("clk_sel", full, clk_sel_en[c])
        end
        for (int m = 0; m < 9; m++) begin
            acc(1'b1, 8'h04, 8'(m));
            `CHK("mode", exp_mode[m], chan_mode[1])
        end
        acc(1'b1, 8'h00, 8'h04);
        `CHK("ph_ch0", 1'b1, mode_undefined[0])
        `CHK("c_evt0", 1'b1, reg_c_events_en[0])
        `CHK("d_evt0", 1'b1, reg_d_events_en[0])
        acc(1'b1, 8'h1c, 8'hff);
        acc(1'b0, 8'h1c, 8'h00);
        `CHK("unmapped", 32'h0, rdata)
        counter_running <= 6'h02;
        acc(1'b1, 8'h04, 8'h02);
        `CHK("wr_run", 1'b1, write_while_running[1])
        end_of_test();
    end
endmodule
`default_nettype wire
